// ---- hdl/impt_pkg.sv ----
// Package: timing, register map, reset values and carrier types of the incremental move and teach block
package impt_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCAN_PERIOD_NS = 1_000_000;
  localparam int SCAN_CYCLES = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCAN_MS = 1;
  localparam int WRITE_HOLD_MS = 20;
  localparam logic [4:0] WRITE_HOLD_SCANS = 5'((WRITE_HOLD_MS + SCAN_MS - 1) / SCAN_MS);

  // ************************************************************
  // Position table geometry
  // ************************************************************
  localparam int TBL_IDX_W = 6;
  localparam int TBL_DEPTH = 64;

  // ************************************************************
  // Register byte offsets
  // ************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_INCH_DIST = 8'h04;
  localparam logic [7:0] REG_JOG_SPEED = 8'h08;
  localparam logic [7:0] REG_DEF_BAND = 8'h0C;
  localparam logic [7:0] REG_SOFT_MIN = 8'h10;
  localparam logic [7:0] REG_SOFT_MAX = 8'h14;
  localparam logic [7:0] REG_TBL_IDX = 8'h18;
  localparam logic [7:0] REG_TBL_POS = 8'h1C;
  localparam logic [7:0] REG_TBL_BAND = 8'h20;
  localparam logic [7:0] REG_TBL_FLAGS = 8'h24;
  localparam logic [7:0] REG_TBL_COMMIT = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h2C;
  localparam logic [7:0] REG_TARGET = 8'h30;
  localparam logic [7:0] REG_CUR_POS = 8'h34;

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int CTRL_TEACH_BIT = 0;
  localparam int FLAG_INCR_BIT = 0;
  localparam int FLAG_PUSH_BIT = 1;
  localparam logic [31:0] INCH_DIST_RST = 32'h0000_0064;
  localparam logic [31:0] JOG_SPEED_RST = 32'h0000_03E8;
  localparam logic [15:0] DEF_BAND_RST = 16'h000A;
  localparam logic [31:0] SOFT_MIN_RST = 32'h0000_0000;
  localparam logic [31:0] SOFT_MAX_RST = 32'h0000_FFFF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_MOVE = 3'b010,
    S_TEACH = 3'b100
  } impt_seq_t;

  typedef struct packed {
    logic signed [31:0] pos;
    logic [15:0] band;
    logic incr;
    logic push;
    logic defined;
  } impt_entry_t;

  typedef struct packed {
    logic [TBL_IDX_W-1:0] pos_select;
    logic start;
    logic teach_req;
    logic jog_plus;
    logic jog_minus;
    logic inch_jog_select;
    logic position_write_request;
  } impt_pio_in_t;

  typedef struct packed {
    logic position_complete;
    logic moving;
    logic teach_active;
    logic write_done;
  } impt_pio_out_t;

  typedef struct packed {
    logic signed [31:0] target;
    logic load;
    logic push;
    logic stop;
    logic jog_plus;
    logic jog_minus;
    logic inch_plus;
    logic inch_minus;
  } impt_mot_cmd_t;

  typedef struct packed {
    logic signed [31:0] position;
    logic busy;
  } impt_mot_stat_t;

endpackage

// ---- hdl/impt_table.sv ----
// Position table memory with registered read data
`timescale 1ns/1ps
module impt_table (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic wr_en,
  input wire logic [impt_pkg::TBL_IDX_W-1:0] wr_idx,
  input wire impt_pkg::impt_entry_t wr_data,
  input wire logic rd_en,
  input wire logic [impt_pkg::TBL_IDX_W-1:0] rd_idx,
  output impt_pkg::impt_entry_t rd_data
);
  import impt_pkg::*;

  impt_entry_t mem [TBL_DEPTH];
  logic [TBL_DEPTH-1:0] defined;

  // Array holds data only; the defined bits are reset so blank entries read as blank
  always_ff @(posedge aclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
    if (!aresetn) begin
      defined <= '0;
      rd_data <= '0;
    end else begin
      if (wr_en) begin
        defined[wr_idx] <= wr_data.defined;
      end
      if (rd_en) begin
        rd_data <= mem[rd_idx];
        rd_data.defined <= defined[rd_idx];
      end
    end
  end
endmodule // impt_table

// ---- hdl/impt_core.sv ----
// Parallel I/O move resolution and teaching logic with an AXI4-Lite register slave
// Behaviour
// - Position complete stays low while start stays high, even after motion ends.
// - Targets past a soft limit stop at the limit, then complete asserts.
// - Each table entry has an incremental flag making its position relative.
// - Incremental positioning start during a move adds the distance to the running target.
// - Repeated incremental starts during one move accumulate onto the target.
// - Incremental positioning start during push motion adds to the push target.
// - Incremental push start during motion adds to the current position.
// - Teaching type enables host jogging and current position writes.
// - Writing a blank entry fills band and flags with defaults.
// - Write request held 20 ms before the current position is stored.
// - Teach request rise enables teaching only while the actuator stands.
// - Both jog inputs stop the actuator; both must release before jogging.
// - Inch select high inches by set distance; low jogs at set speed.
// - Write done rises on store and falls when the request drops.
// - Start rise clears position complete and raises moving.
`timescale 1ns/1ps
module impt_core #(
  parameter int SCAN_CYCLES_P = impt_pkg::SCAN_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire impt_pkg::impt_pio_in_t parallel_io_in,
  output impt_pkg::impt_pio_out_t parallel_io_out,
  input wire impt_pkg::impt_mot_stat_t mot_stat,
  output impt_pkg::impt_mot_cmd_t mot_cmd,
  output logic [31:0] mot_jog_speed,
  output logic [31:0] mot_inch_dist
);
  import impt_pkg::*;

  // ************************************************************
  // State record
  // ************************************************************
  typedef struct packed {
    logic aw_held;
    logic [7:0] awaddr;
    logic w_held;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic teach_type;
    logic [31:0] inch_dist;
    logic [31:0] jog_speed;
    logic [15:0] def_band;
    logic [31:0] soft_min;
    logic [31:0] soft_max;
    logic [TBL_IDX_W-1:0] tbl_idx;
    logic [31:0] tbl_pos;
    logic [15:0] tbl_band;
    logic tbl_incr;
    logic tbl_push;
    logic commit;
    logic [15:0] scan_cnt;
    impt_pio_in_t samp;
    impt_pio_in_t qual;
    impt_pio_in_t qual_prev;
    impt_seq_t state;
    logic start_pend;
    logic signed [31:0] run_target;
    logic run_push;
    logic running;
    logic seen_busy;
    logic done;
    logic [4:0] hold_cnt;
    logic jog_lock;
    impt_pio_out_t out;
    impt_mot_cmd_t cmd;
  } impt_state_t;

  impt_state_t s;
  impt_state_t next_s;
  logic mem_wr_en;
  logic [TBL_IDX_W-1:0] mem_wr_idx;
  impt_entry_t mem_wr_data;
  logic mem_rd_en;
  logic [TBL_IDX_W-1:0] mem_rd_idx;
  impt_entry_t mem_rd_data;

  // Byte-lane merge for partial AXI writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Soft stroke limit clamp
  function automatic logic signed [31:0] clamp(input logic signed [31:0] t, input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    logic signed [31:0] r;
    r = t;
    if (t < lo) begin
      r = lo;
    end else if (t > hi) begin
      r = hi;
    end
    return r;
  endfunction

  // ************************************************************
  // Position table
  // ************************************************************
  impt_table impt_table_inst (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr_en(mem_wr_en),
    .wr_idx(mem_wr_idx),
    .wr_data(mem_wr_data),
    .rd_en(mem_rd_en),
    .rd_idx(mem_rd_idx),
    .rd_data(mem_rd_data)
  );

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic tick;
    logic both;
    logic jog_en;
    logic [7:0] wa;
    logic [7:0] ra;
    logic signed [31:0] tgt;
    impt_pio_in_t q;
    impt_pio_in_t rise;
    impt_entry_t e;
    tick = 1'b0;
    both = 1'b0;
    jog_en = 1'b0;
    wa = {s.awaddr[7:2], 2'b00};
    ra = {s_axi_araddr[7:2], 2'b00};
    tgt = '0;
    q = s.qual;
    rise = s.qual & ~s.qual_prev;
    e = mem_rd_data;
    next_s = s;
    mem_wr_en = 1'b0;
    mem_wr_idx = s.tbl_idx;
    mem_wr_data = '0;
    mem_rd_en = 1'b0;
    mem_rd_idx = q.pos_select;

    // AXI write channels are taken independently, answered once both are held
    if (s_axi_awvalid && !s.aw_held) begin
      next_s.aw_held = 1'b1;
      next_s.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_held) begin
      next_s.w_held = 1'b1;
      next_s.wdata = s_axi_wdata;
      next_s.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s.aw_held && s.w_held && !s.bvalid) begin
      next_s.aw_held = 1'b0;
      next_s.w_held = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = RESP_OKAY;
      case (wa)
        REG_CTRL: begin
          if (s.wstrb[0]) begin
            next_s.teach_type = s.wdata[CTRL_TEACH_BIT];
          end
        end
        REG_INCH_DIST: next_s.inch_dist = lane_merge(s.inch_dist, s.wdata, s.wstrb);
        REG_JOG_SPEED: next_s.jog_speed = lane_merge(s.jog_speed, s.wdata, s.wstrb);
        REG_DEF_BAND: next_s.def_band = 16'(lane_merge({16'h0000, s.def_band}, s.wdata, s.wstrb));
        REG_SOFT_MIN: next_s.soft_min = lane_merge(s.soft_min, s.wdata, s.wstrb);
        REG_SOFT_MAX: next_s.soft_max = lane_merge(s.soft_max, s.wdata, s.wstrb);
        REG_TBL_IDX: next_s.tbl_idx = TBL_IDX_W'(lane_merge({26'h0, s.tbl_idx}, s.wdata, s.wstrb));
        REG_TBL_POS: next_s.tbl_pos = lane_merge(s.tbl_pos, s.wdata, s.wstrb);
        REG_TBL_BAND: next_s.tbl_band = 16'(lane_merge({16'h0000, s.tbl_band}, s.wdata, s.wstrb));
        REG_TBL_FLAGS: begin
          if (s.wstrb[0]) begin
            next_s.tbl_incr = s.wdata[FLAG_INCR_BIT];
            next_s.tbl_push = s.wdata[FLAG_PUSH_BIT];
          end
        end
        REG_TBL_COMMIT: next_s.commit = 1'b1;
        REG_STATUS, REG_TARGET, REG_CUR_POS: next_s.bresp = RESP_OKAY;
        default: next_s.bresp = RESP_SLVERR;
      endcase
    end

    // AXI read: one outstanding, data registered
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = RESP_OKAY;
      case (ra)
        REG_CTRL: next_s.rdata = {31'h0, s.teach_type};
        REG_INCH_DIST: next_s.rdata = s.inch_dist;
        REG_JOG_SPEED: next_s.rdata = s.jog_speed;
        REG_DEF_BAND: next_s.rdata = {16'h0000, s.def_band};
        REG_SOFT_MIN: next_s.rdata = s.soft_min;
        REG_SOFT_MAX: next_s.rdata = s.soft_max;
        REG_TBL_IDX: next_s.rdata = {26'h0, s.tbl_idx};
        REG_TBL_POS: next_s.rdata = s.tbl_pos;
        REG_TBL_BAND: next_s.rdata = {16'h0000, s.tbl_band};
        REG_TBL_FLAGS: next_s.rdata = {30'h0, s.tbl_push, s.tbl_incr};
        REG_TBL_COMMIT: next_s.rdata = {31'h0, s.commit};
        REG_STATUS: next_s.rdata = {26'h0, s.running, s.jog_lock, s.out.write_done, s.out.teach_active,
                                    s.out.moving, s.out.position_complete};
        REG_TARGET: next_s.rdata = s.run_target;
        REG_CUR_POS: next_s.rdata = mot_stat.position;
        default: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = RESP_SLVERR;
        end
      endcase
    end

    // Millisecond scan; a level is accepted only after two equal scans
    tick = (s.scan_cnt == 16'(SCAN_CYCLES_P - 1));
    next_s.scan_cnt = tick ? 16'h0000 : s.scan_cnt + 16'h0001;
    next_s.qual_prev = s.qual;
    if (tick) begin
      next_s.samp = parallel_io_in;
      for (int i = 0; i < $bits(impt_pio_in_t); i++) begin
        if (s.samp[i] == parallel_io_in[i]) begin
          next_s.qual[i] = s.samp[i];
        end
      end
    end

    // Pulses last one cycle
    next_s.cmd.load = 1'b0;
    next_s.cmd.stop = 1'b0;
    next_s.cmd.inch_plus = 1'b0;
    next_s.cmd.inch_minus = 1'b0;

    // Motion tracking: completion needs busy seen then dropped
    if (s.running) begin
      if (mot_stat.busy) begin
        next_s.seen_busy = 1'b1;
      end
      if (s.seen_busy && !mot_stat.busy) begin
        next_s.running = 1'b0;
        next_s.done = 1'b1;
      end
    end
    if (rise.start) begin
      next_s.start_pend = 1'b1;
      next_s.done = 1'b0;
    end

    // Teaching mode entry only from standstill
    if (!q.teach_req || !s.teach_type) begin
      next_s.out.teach_active = 1'b0;
    end else if (rise.teach_req && !mot_stat.busy && !s.running) begin
      next_s.out.teach_active = 1'b1;
    end

    // Jog and inch; both directions at once stop and lock out
    both = q.jog_plus & q.jog_minus;
    if (both) begin
      next_s.jog_lock = 1'b1;
      if (!s.jog_lock) begin
        next_s.cmd.stop = 1'b1;
      end
    end else if (!q.jog_plus && !q.jog_minus) begin
      next_s.jog_lock = 1'b0;
    end
    jog_en = s.out.teach_active & ~s.jog_lock & ~both & ~s.running;
    next_s.cmd.jog_plus = jog_en & ~q.inch_jog_select & q.jog_plus;
    next_s.cmd.jog_minus = jog_en & ~q.inch_jog_select & q.jog_minus;
    next_s.cmd.inch_plus = jog_en & q.inch_jog_select & rise.jog_plus;
    next_s.cmd.inch_minus = jog_en & q.inch_jog_select & rise.jog_minus;

    // Write request hold counter in scans; dropping it clears write done
    if (!q.position_write_request) begin
      next_s.hold_cnt = 5'h00;
      next_s.out.write_done = 1'b0;
    end else if (tick && s.hold_cnt != WRITE_HOLD_SCANS) begin
      next_s.hold_cnt = s.hold_cnt + 5'h01;
    end

    // Sequencer; the table read takes one cycle
    case (s.state)
      S_IDLE: begin
        if (s.start_pend) begin
          mem_rd_en = 1'b1;
          next_s.start_pend = 1'b0;
          next_s.state = S_MOVE;
        end else if (s.out.teach_active && q.position_write_request && s.hold_cnt == WRITE_HOLD_SCANS &&
                     !s.out.write_done && !mot_stat.busy) begin
          mem_rd_en = 1'b1;
          next_s.state = S_TEACH;
        end else if (s.commit) begin
          mem_wr_en = 1'b1;
          mem_wr_data = '{pos: s.tbl_pos, band: s.tbl_band, incr: s.tbl_incr, push: s.tbl_push, defined: 1'b1};
          next_s.commit = 1'b0;
        end
      end
      S_MOVE: begin
        next_s.state = S_IDLE;
        if (!e.defined) begin
          next_s.done = !s.running;
        end else begin
          if (!e.incr) begin
            tgt = e.pos;
          end else if (s.running && e.push) begin
            tgt = mot_stat.position + e.pos;
          end else if (s.running) begin
            tgt = s.run_target + e.pos;
          end else begin
            tgt = mot_stat.position + e.pos;
          end
          tgt = clamp(tgt, s.soft_min, s.soft_max);
          next_s.run_target = tgt;
          next_s.run_push = e.push;
          next_s.running = 1'b1;
          next_s.seen_busy = 1'b0;
          next_s.done = 1'b0;
          next_s.cmd.target = tgt;
          next_s.cmd.push = e.push;
          next_s.cmd.load = 1'b1;
        end
      end
      S_TEACH: begin
        next_s.state = S_IDLE;
        mem_wr_en = 1'b1;
        mem_wr_idx = q.pos_select;
        mem_wr_data = e;
        mem_wr_data.pos = mot_stat.position;
        if (!e.defined) begin
          mem_wr_data.band = s.def_band;
          mem_wr_data.incr = 1'b0;
          mem_wr_data.push = 1'b0;
          mem_wr_data.defined = 1'b1;
        end
        next_s.out.write_done = 1'b1;
      end
      default: next_s.state = S_IDLE;
    endcase

    // Status outputs; complete held low while start is still high
    next_s.out.position_complete = next_s.done & ~q.start;
    next_s.out.moving = next_s.running | next_s.start_pend | (next_s.state == S_MOVE);
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
      s.state <= S_IDLE;
      s.inch_dist <= INCH_DIST_RST;
      s.jog_speed <= JOG_SPEED_RST;
      s.def_band <= DEF_BAND_RST;
      s.soft_min <= SOFT_MIN_RST;
      s.soft_max <= SOFT_MAX_RST;
    end else begin
      s <= next_s;
    end
  end

  // Port drive
  assign s_axi_awready = !s.aw_held;
  assign s_axi_wready = !s.w_held;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_bresp = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid = s.rvalid;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign parallel_io_out = s.out;
  assign mot_cmd = s.cmd;
  assign mot_jog_speed = s.jog_speed;
  assign mot_inch_dist = s.inch_dist;
endmodule // impt_core

// ---- tb/impt_core_properties.sv ----
// Checker of port-level timing rules for the move and teach block
`timescale 1ns/1ps
module impt_core_properties #(
  parameter int SCAN_CYCLES_P = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire impt_pkg::impt_pio_in_t parallel_io_in,
  input wire impt_pkg::impt_pio_out_t parallel_io_out,
  input wire impt_pkg::impt_mot_stat_t mot_stat,
  input wire impt_pkg::impt_mot_cmd_t mot_cmd
);
  import impt_pkg::*;
  localparam int QMAX = 3 * SCAN_CYCLES_P + 3;
  localparam int WMIN = 20 * SCAN_CYCLES_P;
  // ****************
  // Helper logic
  // ****************
  // Raw hold time of the write request; saturates so it never wraps
  logic [15:0] req_cnt;
  always_ff @(posedge aclk) begin
    if (!aresetn || !parallel_io_in.position_write_request) begin
      req_cnt <= 16'h0;
    end else if (req_cnt != 16'hFFFF) begin
      req_cnt <= req_cnt + 16'h1;
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_load_moving;
    mot_cmd.load |-> parallel_io_out.moving && !parallel_io_out.position_complete;
  endproperty
  a_load_moving: assert property (p_load_moving) else $error("load outside a move");
  property p_move_start;
    $rose(parallel_io_out.moving) |-> $past(parallel_io_in.start);
  endproperty
  a_move_start: assert property (p_move_start) else $error("moving without start");
  property p_done_nostart;
    $rose(parallel_io_out.position_complete) |-> !$past(parallel_io_in.start);
  endproperty
  a_done_nostart: assert property (p_done_nostart) else $error("complete while start held");
  property p_teach_still;
    $rose(parallel_io_out.teach_active) |-> !$past(mot_stat.busy) && parallel_io_in.teach_req;
  endproperty
  a_teach_still: assert property (p_teach_still) else $error("teach entered in motion");
  property p_jog_gate;
    (mot_cmd.jog_plus || mot_cmd.jog_minus || mot_cmd.inch_plus || mot_cmd.inch_minus)
      |-> $past(parallel_io_out.teach_active);
  endproperty
  a_jog_gate: assert property (p_jog_gate) else $error("jog outside teaching");
  property p_both_stop;
    $rose(parallel_io_in.jog_plus && parallel_io_in.jog_minus) && parallel_io_out.teach_active
      |-> ##[1:QMAX] mot_cmd.stop;
  endproperty
  a_both_stop: assert property (p_both_stop) else $error("no stop on both jogs");
  property p_write_hold;
    $rose(parallel_io_out.write_done) |-> req_cnt >= WMIN && parallel_io_out.teach_active;
  endproperty
  a_write_hold: assert property (p_write_hold) else $error("write done too early");
  property p_write_drop;
    parallel_io_out.write_done && $fell(parallel_io_in.position_write_request)
      |-> ##[1:QMAX] !parallel_io_out.write_done;
  endproperty
  a_write_drop: assert property (p_write_drop) else $error("write done stuck");
  property p_inch_sel;
    mot_cmd.inch_plus || mot_cmd.inch_minus |-> parallel_io_in.inch_jog_select;
  endproperty
  a_inch_sel: assert property (p_inch_sel) else $error("inch without select");
endmodule // impt_core_properties
bind impt_core impt_core_properties #(.SCAN_CYCLES_P(SCAN_CYCLES_P)) impt_core_properties_inst (
  .aclk(aclk), .aresetn(aresetn), .parallel_io_in(parallel_io_in), .parallel_io_out(parallel_io_out),
  .mot_stat(mot_stat), .mot_cmd(mot_cmd));

// ---- tb/impt_motor_model.sv ----
// Behavioural motion engine answering the block's motion commands other than inch_plus
`timescale 1ns/1ps
module impt_motor_model #(
  parameter int BUSY_CYC = 150
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire impt_pkg::impt_mot_cmd_t mot_cmd,
  input wire logic [31:0] mot_inch_dist,
  output impt_pkg::impt_mot_stat_t mot_stat
);
  import impt_pkg::*;
  int cnt;
  logic signed [31:0] tgt;
  // A load restarts travel; position only lands at the end, so mid-move reads see the old spot
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 0;
      tgt <= 32'h0;
      mot_stat <= '0;
    end else if (mot_cmd.stop) begin
      cnt <= 0;
      mot_stat.busy <= 1'b0;
    end else if (mot_cmd.load) begin
      cnt <= BUSY_CYC;
      tgt <= mot_cmd.target;
      mot_stat.busy <= 1'b1;
    end else if (cnt == 1) begin
      cnt <= 0;
      mot_stat <= {tgt, 1'b0};
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      mot_stat.busy <= mot_cmd.jog_plus | mot_cmd.jog_minus;
      if (mot_cmd.jog_plus) mot_stat.position <= mot_stat.position + 32'h1;
      if (mot_cmd.jog_minus) mot_stat.position <= mot_stat.position - 32'h1;
      if (mot_cmd.inch_minus) mot_stat.position <= mot_stat.position - mot_inch_dist;
    end
  end
endmodule // impt_motor_model

// ---- tb/impt_core_tb.sv ----
// Testbench of incremental move resolution and parallel I/O teaching
`timescale 1ns/1ps
module impt_core_tb;
  import impt_pkg::*;
  localparam int SC = 4;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic [1:0] r;} impt_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, mot_jog_speed, mot_inch_dist, v, p;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  impt_pio_in_t pi = '0;
  impt_pio_out_t po;
  impt_mot_stat_t mot_stat;
  impt_mot_cmd_t mot_cmd;
  int num_errors = 0, check_count = 0, cycles = 0, n;
  impt_row_t rows [6] = '{'{REG_INCH_DIST, INCH_DIST_RST, RESP_OKAY}, '{REG_JOG_SPEED, JOG_SPEED_RST, RESP_OKAY},
    '{REG_DEF_BAND, 32'(DEF_BAND_RST), RESP_OKAY}, '{REG_SOFT_MIN, SOFT_MIN_RST, RESP_OKAY},
    '{REG_SOFT_MAX, SOFT_MAX_RST, RESP_OKAY}, '{8'hFC, 32'h0, RESP_SLVERR}};
  impt_core #(.SCAN_CYCLES_P(SC)) impt_core_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .parallel_io_in(pi), .parallel_io_out(po), .mot_stat, .mot_cmd, .mot_jog_speed, .mot_inch_dist);
  impt_motor_model impt_motor_model_inst (.aclk, .aresetn, .mot_cmd, .mot_inch_dist, .mot_stat);
  // ****************
  // Clock, timeout, tasks
  // ****************
  // Free-running clock at 100 ns
  initial forever #50 aclk = ~aclk;
  // Hang guard well above the whole run length
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // Address and data offered together; each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic ent(input logic [5:0] e, input logic [31:0] pos, input logic [1:0] f);
    wr(REG_TBL_IDX, 32'(e));
    wr(REG_TBL_POS, pos);
    wr(REG_TBL_FLAGS, 32'(f));
    wr(REG_TBL_COMMIT, 32'h1);
  endtask
  // Start holds until seen, then drops once complete is off
  task automatic st(input logic [5:0] e);
    pi.pos_select <= e;
    cyc(6 * SC);
    pi.start <= 1'b1;
    cyc(3 * SC + 2);
    while (!(po.moving && !po.position_complete)) @(posedge aclk);
    pi.start <= 1'b0;
  endtask
  task automatic tgt(input logic [31:0] exp);
    while (po.position_complete !== 1'b1) @(posedge aclk);
    rd(REG_TARGET);
    chk(v, exp);
  endtask
  // ****************
  // Main sequence
  // ****************
  // Reset values, refused offsets, then moves and teaching
  initial begin
    cyc(5);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (rows[i]) begin
      rd(rows[i].a);
      chk(v, rows[i].d);
      chk(32'(r), 32'(rows[i].r));
    end
    chk(mot_jog_speed, JOG_SPEED_RST);
    wr(8'hFC, 32'h1);
    chk(32'(r), 32'(RESP_SLVERR));
    ent(1, 32'hC8, 2'h0);
    ent(2, 32'hF, 2'h1);
    ent(3, 32'hC8, 2'h2);
    ent(4, 32'hF, 2'h3);
    ent(6, 32'hFFFF_FFF1, 2'h1);
    st(1);
    st(2);
    st(2);
    tgt(32'hE6);
    pi.pos_select <= 6'h1;
    cyc(6 * SC);
    pi.start <= 1'b1;
    cyc(200 + 10 * SC);
    chk(32'(po.position_complete), 32'h0);
    pi.start <= 1'b0;
    tgt(32'hC8);
    st(3);
    st(2);
    tgt(32'hD7);
    st(3);
    st(4);
    tgt(32'hE6);
    wr(REG_SOFT_MAX, 32'hF0);
    st(2);
    tgt(32'hF0);
    st(6);
    tgt(32'hE1);
    wr(REG_CTRL, 32'h1);
    pi.teach_req <= 1'b1;
    cyc(3 * SC + 4);
    chk(32'(po.teach_active), 32'h1);
    pi.jog_plus <= 1'b1;
    cyc(10 * SC);
    pi.jog_plus <= 1'b0;
    cyc(4 * SC);
    rd(REG_CUR_POS);
    chk(32'(v > 32'hE1), 32'h1);
    pi.jog_plus <= 1'b1;
    pi.jog_minus <= 1'b1;
    cyc(4 * SC);
    pi.jog_plus <= 1'b0;
    pi.jog_minus <= 1'b0;
    pi.inch_jog_select <= 1'b1;
    cyc(4 * SC);
    rd(REG_CUR_POS);
    p = v - INCH_DIST_RST;
    pi.jog_minus <= 1'b1;
    cyc(4 * SC);
    pi.jog_minus <= 1'b0;
    cyc(4 * SC);
    rd(REG_CUR_POS);
    chk(v, p);
    pi.pos_select <= 6'h5;
    pi.position_write_request <= 1'b1;
    n = 0;
    while (po.write_done !== 1'b1) begin
      @(posedge aclk);
      n++;
    end
    chk(32'(n >= 20 * SC), 32'h1);
    pi.position_write_request <= 1'b0;
    pi.teach_req <= 1'b0;
    cyc(3 * SC + 3);
    chk(32'(po.write_done), 32'h0);
    st(5);
    tgt(p);
    stop_test();
  end
endmodule // impt_core_tb
